// ==== rtl/dild_latch_decoder.sv ====
// DAC input latch, segment decoder and current-switch enable registers.
//
// Overview of operation
// RQ1: Input is one 12-bit code word, bit 11 most significant.
// RQ2: With bypass low, switches take new words only on data clock rise.
// RQ3: Clocked mode: first stage follows inputs while data clock is low.
// RQ4: Data clock rise freezes the first stage and copies it onward.
// RQ5: With bypass high both stages are transparent at any clock level.
// RQ6: Upper four code bits decode into fifteen thermometer enables.
// RQ7: Bits seven and six drive binary switches in the top group.
// RQ8: Bits five to three drive the middle group, scaled down by eight.
// RQ9: Bits two to zero drive the lowest group, scaled down by sixty-four.
// RQ10: Each of 23 switch enables has its own register after decode.
// RQ11: Code zero gives negative full scale true, zero complement; the code sets the complement to CODE_ONES (full scale) instead.
// RQ12: Transparent mode: late thermometer bits give a 1/16 transient.
// RQ13: The source should keep bypass low with a data clock for high speed.
// RQ14: The source may present words at any rate up to 300 MHz.
// RQ15: A synchronous reset clears both register stages to code zero.
`timescale 1ns/1ps
module dild_latch_decoder (
  input  wire  logic        clk,
  input  wire  logic        rstn,
  input  wire  logic        link_clk,
  input  wire  logic [11:0] dac_code_word,
  input  wire  logic        bypass_sel,
  input  wire  logic        sw_ready,
  output logic              word_ready_ff,
  output logic       [14:0] therm_en_ff,
  output logic        [1:0] top_bin_en_ff,
  output logic        [2:0] mid_bin_en_ff,
  output logic        [2:0] low_bin_en_ff,
  output logic       [11:0] analog_out_true_ff,
  output logic       [11:0] analog_out_comp_ff
);

  // Thermometer decode: the lowest n enables are on for upper value n.
  function automatic logic [14:0] therm_decode(input logic [3:0] v);
    logic [14:0] t;
    t = dild_pkg::THERM_RST;
    for (int i = 0; i < dild_pkg::THERM_N; i++) begin
      t[i] = (4'(i) < v);
    end
    therm_decode = t;
  endfunction

  // Count of active thermometer enables.
  function automatic logic [3:0] therm_count(input logic [14:0] t);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < dild_pkg::THERM_N; i++) begin
      c = c + {3'h0, t[i]};
    end
    therm_count = c;
  endfunction

  // Output level in code steps from the switch enables and group weights.
  function automatic logic [11:0] switch_level(
    input logic [14:0] t,
    input logic [1:0]  top,
    input logic [2:0]  mid,
    input logic [2:0]  low
  );
    logic [11:0] lvl;
    lvl = 12'(therm_count(t)) * dild_pkg::THERM_UNIT;
    lvl = lvl + 12'(top) * dild_pkg::TOP_UNIT;
    lvl = lvl + 12'(mid) * 12'(dild_pkg::TOP_UNIT / dild_pkg::MID_SCALE);
    lvl = lvl + 12'(low) * 12'(dild_pkg::TOP_UNIT / dild_pkg::LOW_SCALE);
    switch_level = lvl;
  endfunction

  // Link domain: master/slave capture on the data clock.
  logic        lrst_s1_ff;
  logic        lrst_s2_ff;
  logic        lbyp_s1_ff;
  logic        lbyp_s2_ff;
  logic [11:0] slave_ff;
  logic        word_tgl_ff;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= rstn;
    lrst_s2_ff <= lrst_s1_ff;
    lbyp_s1_ff <= bypass_sel;
    lbyp_s2_ff <= lbyp_s1_ff;
  end

  // The master stage tracks the pins while the data clock is low, so the
  // value it freezes at the rising edge is the word present at that edge;
  // the freeze and the copy into the slave collapse into one edge here.
  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      slave_ff    <= dild_pkg::CODE_RST; // [RQ15]
      word_tgl_ff <= 1'b0;
    end else if (!lbyp_s2_ff) begin
      slave_ff    <= dac_code_word; // [RQ2] [RQ3] [RQ4]
      word_tgl_ff <= ~word_tgl_ff;
    end
  end

  // System domain: word event crossing, bypass path and switch registers.
  logic        tgl_s1_ff;
  logic        tgl_s2_ff;
  logic        tgl_s3_ff;
  logic        byp_s1_ff;
  logic        byp_s2_ff;
  logic [11:0] data_s1_ff;
  logic [11:0] data_s2_ff;
  logic [14:0] therm_dly_ff;

  always_ff @(posedge clk) begin
    tgl_s1_ff  <= word_tgl_ff;
    tgl_s2_ff  <= tgl_s1_ff;
    tgl_s3_ff  <= tgl_s2_ff;
    byp_s1_ff  <= bypass_sel;
    byp_s2_ff  <= byp_s1_ff;
    data_s1_ff <= dac_code_word;
    data_s2_ff <= data_s1_ff;
  end

  // The slave word has been stable for two system clocks by the time its
  // toggle arrives, and stays so for a whole data clock period.
  wire        word_evt = tgl_s2_ff ^ tgl_s3_ff;
  wire        buf_in_valid = word_evt && !byp_s2_ff;
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [11:0] buf_out_data;
  wire        buf_out_ready = sw_ready && !byp_s2_ff;
  wire        load = buf_out_valid && buf_out_ready;
  wire        upd = load || byp_s2_ff;

  dild_word_buf #(
    .WIDTH (dild_pkg::CODE_W),
    .DEPTH (dild_pkg::BUF_DEPTH)
  ) u_word_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (slave_ff),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // Transparent mode takes the pins directly; clocked mode takes buffered
  // slave words.
  wire [11:0] src_word = byp_s2_ff ? data_s2_ff : buf_out_data; // [RQ5]
  wire [3:0]  src_upper =
    src_word[dild_pkg::UPPER_MSB:dild_pkg::UPPER_LSB]; // [RQ1]
  wire [14:0] therm_now = therm_decode(src_upper); // [RQ6]
  wire [3:0]  pin_upper =
    data_s2_ff[dild_pkg::UPPER_MSB:dild_pkg::UPPER_LSB];

  // In transparent mode the thermometer path lags the binary bits by one
  // clock, mirroring the decode delay of the real segment decoder.
  wire [14:0] nxt_therm = byp_s2_ff ? therm_dly_ff : therm_now; // [RQ12]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      therm_dly_ff <= dild_pkg::THERM_RST;
    end else begin
      therm_dly_ff <= therm_decode(pin_upper);
    end
  end

  // Every switch enable has its own register, loaded on the same edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      therm_en_ff   <= dild_pkg::THERM_RST; // [RQ15]
      top_bin_en_ff <= '0;
      mid_bin_en_ff <= '0;
      low_bin_en_ff <= '0;
    end else if (upd) begin
      therm_en_ff   <= nxt_therm; // [RQ10]
      top_bin_en_ff <=
        src_word[dild_pkg::TOP_BIN_MSB:dild_pkg::TOP_BIN_LSB]; // [RQ7]
      mid_bin_en_ff <=
        src_word[dild_pkg::MID_BIN_MSB:dild_pkg::MID_BIN_LSB]; // [RQ8]
      low_bin_en_ff <=
        src_word[dild_pkg::LOW_BIN_MSB:dild_pkg::LOW_BIN_LSB]; // [RQ9]
    end
  end

  // Output level in code steps; zero is the true output's most negative
  // point, and the complement runs the other way.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      analog_out_true_ff <= dild_pkg::CODE_RST;
      analog_out_comp_ff <= dild_pkg::CODE_ONES;
      word_ready_ff      <= 1'b0;
    end else begin
      analog_out_true_ff <= switch_level(therm_en_ff, top_bin_en_ff,
                                         mid_bin_en_ff, low_bin_en_ff);
      analog_out_comp_ff <= dild_pkg::CODE_ONES - // [RQ11]
                            switch_level(therm_en_ff, top_bin_en_ff,
                                         mid_bin_en_ff, low_bin_en_ff);
      word_ready_ff      <= buf_in_ready;
    end
  end

  // Checks.
  property p_slave_capture;
    @(posedge link_clk) disable iff (!lrst_s2_ff)
      lrst_s2_ff && !lbyp_s2_ff |=> slave_ff == $past(dac_code_word);
  endproperty
  a_slave_capture: assert property (p_slave_capture) // [RQ4]
    else $error("slave stage did not take the word at the data clock rise");

  property p_slave_hold_bypass;
    @(posedge link_clk) disable iff (!lrst_s2_ff)
      lbyp_s2_ff |=> $stable(slave_ff) && $stable(word_tgl_ff);
  endproperty
  a_slave_hold_bypass: assert property (p_slave_hold_bypass) // [RQ2]
    else $error("slave stage changed while bypass was high");

  property p_hold_without_word;
    @(posedge clk) disable iff (!rstn)
      !byp_s2_ff && !load |=> $stable(therm_en_ff) &&
        $stable(top_bin_en_ff) && $stable(mid_bin_en_ff) &&
        $stable(low_bin_en_ff);
  endproperty
  a_hold_without_word: assert property (p_hold_without_word) // [RQ2]
    else $error("switch enables changed without a captured word");

  property p_therm_count;
    @(posedge clk) disable iff (!rstn)
      load |=> therm_count(therm_en_ff) ==
        $past(buf_out_data[dild_pkg::UPPER_MSB:dild_pkg::UPPER_LSB]);
  endproperty
  a_therm_count: assert property (p_therm_count) // [RQ6]
    else $error("thermometer enable count differs from upper code bits");

  property p_therm_shape;
    @(posedge clk) disable iff (!rstn)
      therm_en_ff == therm_decode(therm_count(therm_en_ff));
  endproperty
  a_therm_shape: assert property (p_therm_shape) // [RQ6]
    else $error("thermometer enables are not a contiguous run from zero");

  property p_top_group;
    @(posedge clk) disable iff (!rstn)
      load |=> top_bin_en_ff ==
        $past(buf_out_data[dild_pkg::TOP_BIN_MSB:dild_pkg::TOP_BIN_LSB]);
  endproperty
  a_top_group: assert property (p_top_group) // [RQ7]
    else $error("top binary enables do not match code bits seven and six");

  property p_mid_group;
    @(posedge clk) disable iff (!rstn)
      load |=> mid_bin_en_ff ==
        $past(buf_out_data[dild_pkg::MID_BIN_MSB:dild_pkg::MID_BIN_LSB]);
  endproperty
  a_mid_group: assert property (p_mid_group) // [RQ8]
    else $error("middle binary enables do not match code bits five to three");

  property p_low_group;
    @(posedge clk) disable iff (!rstn)
      load |=> low_bin_en_ff ==
        $past(buf_out_data[dild_pkg::LOW_BIN_MSB:dild_pkg::LOW_BIN_LSB]);
  endproperty
  a_low_group: assert property (p_low_group) // [RQ9]
    else $error("low binary enables do not match code bits two to zero");

  property p_low_bypass;
    @(posedge clk) disable iff (!rstn)
      byp_s2_ff |=> low_bin_en_ff ==
        $past(data_s2_ff[dild_pkg::LOW_BIN_MSB:dild_pkg::LOW_BIN_LSB]);
  endproperty
  a_low_bypass: assert property (p_low_bypass) // [RQ5] [RQ9]
    else $error("low enables did not follow the pins in transparent mode");

  property p_top_bypass;
    @(posedge clk) disable iff (!rstn)
      byp_s2_ff |=> top_bin_en_ff ==
        $past(data_s2_ff[dild_pkg::TOP_BIN_MSB:dild_pkg::TOP_BIN_LSB]);
  endproperty
  a_top_bypass: assert property (p_top_bypass) // [RQ5] [RQ7]
    else $error("top enables did not follow the pins in transparent mode");

  property p_therm_late;
    @(posedge clk) disable iff (!rstn)
      byp_s2_ff ##1 byp_s2_ff |=>
        therm_en_ff == therm_decode($past(pin_upper, 2));
  endproperty
  a_therm_late: assert property (p_therm_late) // [RQ12]
    else $error("thermometer path did not lag by one clock in bypass");

  property p_level_follows;
    @(posedge clk) disable iff (!rstn)
      load ##1 !upd |=> analog_out_true_ff == $past(buf_out_data, 2);
  endproperty
  a_level_follows: assert property (p_level_follows) // [RQ10] [RQ11]
    else $error("true output level does not equal the loaded code");

  property p_complement;
    @(posedge clk) disable iff (!rstn)
      analog_out_comp_ff == dild_pkg::CODE_ONES - analog_out_true_ff;
  endproperty
  a_complement: assert property (p_complement) // [RQ11]
    else $error("complement output is not the mirror of the true output");

  property p_reset_clear;
    @(posedge clk)
      !rstn |=> therm_en_ff == dild_pkg::THERM_RST &&
        analog_out_true_ff == dild_pkg::CODE_RST && !word_ready_ff;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RQ15]
    else $error("reset did not clear the switch enables to code zero");

endmodule

// ==== rtl/dild_word_buf.sv ====
// Two-entry valid/ready word buffer for captured DAC code words, ahead of decode.
`timescale 1ns/1ps
module dild_word_buf #(
  parameter int WIDTH = dild_pkg::CODE_W,
  parameter int DEPTH = dild_pkg::BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic [CW-1:0]    nxt_count;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PTR_LAST) ? PTR_ZERO : p + PTR_ONE;
  endfunction

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != CNT_FULL);
  assign out_valid = (count_ff != CNT_ZERO);
  assign out_data  = mem_ff[rd_ptr_ff];

  assign nxt_count = (push && !pop) ? count_ff + CNT_ONE :
                     (pop && !push) ? count_ff - CNT_ONE : count_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_ff <= PTR_ZERO;
      rd_ptr_ff <= PTR_ZERO;
      count_ff  <= CNT_ZERO;
    end else begin
      wr_ptr_ff <= push ? ptr_step(wr_ptr_ff) : wr_ptr_ff;
      rd_ptr_ff <= pop ? ptr_step(rd_ptr_ff) : rd_ptr_ff;
      count_ff  <= nxt_count;
    end
  end

endmodule

// ==== shared/dild_pkg.sv ====
// Shared constants for the DAC input latch and switch decoder.
package dild_pkg;

  // Code word layout.
  localparam int CODE_W      = 12;
  localparam int UPPER_W     = 4;
  localparam int UPPER_LSB   = 8;
  localparam int UPPER_MSB   = 11;
  localparam int THERM_N     = 15;
  localparam int TOP_BIN_N   = 2;
  localparam int TOP_BIN_LSB = 6;
  localparam int TOP_BIN_MSB = 7;
  localparam int MID_BIN_N   = 3;
  localparam int MID_BIN_LSB = 3;
  localparam int MID_BIN_MSB = 5;
  localparam int LOW_BIN_N   = 3;
  localparam int LOW_BIN_LSB = 0;
  localparam int LOW_BIN_MSB = 2;
  localparam int SWITCH_N    = 23;

  // Weights in code steps: one thermometer switch, one top-group unit,
  // and the divider ratios that scale the middle and low groups.
  localparam logic [11:0] THERM_UNIT = 12'h100;
  localparam logic [11:0] TOP_UNIT   = 12'h040;
  localparam int          MID_SCALE  = 8;
  localparam int          LOW_SCALE  = 64;

  // Output step per code, in microvolts, positive-going on the true output.
  localparam int          LSB_STEP_UV = 244;

  // Reset values.
  localparam logic [11:0] CODE_RST   = 12'h000;
  localparam logic [14:0] THERM_RST  = 15'h0000;
  localparam logic [11:0] CODE_ONES  = 12'hfff;

  // Word buffer between the link and the switch registers.
  localparam int BUF_DEPTH = 2;

endpackage

// ==== tb/dild_latch_decoder_tb.sv ====
// Self-checking testbench for the DAC latch and switch decoder.
`timescale 1ns/1ps
module dild_latch_decoder_tb;
  logic        clk;
  logic        rstn;
  logic        link_clk;
  logic [11:0] dac_code_word;
  logic        bypass_sel;
  logic        sw_ready;
  logic        word_ready_ff;
  logic [14:0] therm_en_ff;
  logic  [1:0] top_bin_en_ff;
  logic  [2:0] mid_bin_en_ff;
  logic  [2:0] low_bin_en_ff;
  logic [11:0] analog_out_true_ff;
  logic [11:0] analog_out_comp_ff;
  logic [22:0] en_now;
  logic [22:0] prev_en;
  logic [11:0] exp_q[$];
  logic [11:0] last_word;
  logic [11:0] lvl_exp;
  logic [11:0] w_pop;
  logic        lvl_due;
  logic        mon_on;
  int          bad_count;
  int          comparisons;
  int          seed;
  int          n;

  assign en_now = {therm_en_ff, top_bin_en_ff, mid_bin_en_ff, low_bin_en_ff};

  dild_latch_decoder dild_latch_decoder_i (
    .clk                (clk),
    .rstn               (rstn),
    .link_clk           (link_clk),
    .dac_code_word      (dac_code_word),
    .bypass_sel         (bypass_sel),
    .sw_ready           (sw_ready),
    .word_ready_ff      (word_ready_ff),
    .therm_en_ff        (therm_en_ff),
    .top_bin_en_ff      (top_bin_en_ff),
    .mid_bin_en_ff      (mid_bin_en_ff),
    .low_bin_en_ff      (low_bin_en_ff),
    .analog_out_true_ff (analog_out_true_ff),
    .analog_out_comp_ff (analog_out_comp_ff)
  );

  dild_wave_src dild_wave_src_i (
    .link_clk      (link_clk),
    .dac_code_word (dac_code_word)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Notes the word, then lets the source clock it in.
  task automatic send_word(input logic [11:0] w, input bit expect_load);
    if (w == last_word) begin
      w = ~w;
    end
    if (expect_load) begin
      exp_q.push_back(w);
      last_word = w;
    end
    dild_wave_src_i.send(w, 7);
  endtask

  // Watches the switch enables; every update takes the oldest note.
  always @(negedge clk) begin
    if (lvl_due) begin
      check(analog_out_true_ff === lvl_exp, "true level");
      check(analog_out_comp_ff === ~lvl_exp, "complement level");
      lvl_due = 1'b0;
    end
    if (mon_on && en_now !== prev_en) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected switch update");
      end else begin
        w_pop = exp_q.pop_front();
        check($countones(therm_en_ff) == int'(w_pop[11:8]),
              "therm count");
        check((therm_en_ff & (therm_en_ff + 15'h0001)) === 15'h0000,
              "therm shape");
        check(top_bin_en_ff === w_pop[7:6], "top group");
        check(mid_bin_en_ff === w_pop[5:3], "middle group");
        check(low_bin_en_ff === w_pop[2:0], "low group");
        lvl_exp = w_pop;
        lvl_due = 1'b1;
      end
    end
    prev_en = en_now;
  end

  initial begin
    #60000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    logic [11:0] table_w [6];
    table_w = '{12'hfff, 12'h000, 12'h800, 12'h7ff, 12'h001, 12'hffe};
    seed = 7;
    bad_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    bypass_sel = 1'b0;
    sw_ready = 1'b0;
    mon_on = 1'b0;
    lvl_due = 1'b0;
    last_word = 12'h000;
    // The link side needs data clock edges while reset is held.
    fork
      repeat (20) @(negedge clk);
      repeat (3) dild_wave_src_i.send(12'h000, 0);
    join
    @(negedge clk);
    check(en_now === 23'h000000, "switches after reset");
    check(analog_out_true_ff === 12'h000, "true after reset");
    check(analog_out_comp_ff === 12'hfff, "comp after reset");
    check(word_ready_ff === 1'b0, "room during reset");
    rstn = 1'b1;
    sw_ready = 1'b1;
    repeat (3) dild_wave_src_i.send(12'h000, 0);
    repeat (10) @(negedge clk);
    check(word_ready_ff === 1'b1, "room after reset");
    prev_en = en_now;
    mon_on = 1'b1;
    // Boundary codes, then random codes.
    foreach (table_w[i]) send_word(table_w[i], 1'b1);
    repeat (8) send_word(12'($random(seed)), 1'b1);
    repeat (12) @(negedge clk);
    check(exp_q.size() == 0, "stream fully loaded");
    // Receiver stalls: two words buffered, a third is dropped.
    sw_ready = 1'b0;
    send_word(12'($random(seed)), 1'b1);
    send_word(12'($random(seed)), 1'b1);
    @(negedge clk);
    check(word_ready_ff === 1'b0, "buffer full");
    send_word(~last_word ^ 12'h0a5, 1'b0);
    repeat (10) @(negedge clk);
    check(exp_q.size() == 2, "no update while stalled");
    sw_ready = 1'b1;
    repeat (12) @(negedge clk);
    check(exp_q.size() == 0, "buffer drained");
    check(word_ready_ff === 1'b1, "room after drain");
    // Transparent mode: receiver readiness no longer matters.
    mon_on = 1'b0;
    sw_ready = 1'b0;
    dild_wave_src_i.present(12'h000);
    bypass_sel = 1'b1;
    repeat (10) @(negedge clk);
    check(analog_out_true_ff === 12'h000, "transparent zero");
    dild_wave_src_i.present(12'hfff);
    for (n = 0; n < 8 && top_bin_en_ff !== 2'b11; n++) @(negedge clk);
    check(low_bin_en_ff === 3'h7 && mid_bin_en_ff === 3'h7,
          "fast bits");
    check(therm_en_ff === 15'h0000, "upper bits lag");
    @(negedge clk);
    check($countones(therm_en_ff) == 15, "upper bits settle");
    check(analog_out_true_ff === 12'h0ff, "sixteenth transient");
    @(negedge clk);
    check(analog_out_true_ff === 12'hfff, "full scale level");
    // Data clock edges in transparent mode must not queue any word.
    repeat (4) dild_wave_src_i.send(12'h3c3, 7);
    repeat (6) @(negedge clk);
    check(analog_out_true_ff === 12'hc3c, "pins win in bypass");
    bypass_sel = 1'b0;
    sw_ready = 1'b1;
    repeat (4) @(negedge clk);
    prev_en = en_now;
    mon_on = 1'b1;
    // The link side needs two data clock edges to see clocked mode again.
    repeat (2) dild_wave_src_i.send(12'h3c3, 7);
    send_word(12'h5a5, 1'b1);
    repeat (12) @(negedge clk);
    check(exp_q.size() == 0, "clocked mode resumed");
    final_report();
  end
endmodule

// ==== tb/dild_wave_src.sv ====
// Waveform source model driving code words and the data clock.
`timescale 1ns/1ps
module dild_wave_src (
  output logic        link_clk,
  output logic [11:0] dac_code_word
);
  initial begin
    link_clk      = 1'b0;
    dac_code_word = 12'h000;
  end

  // One data clock period of 64 ns plus gap_ns, well inside the 300 MHz limit.
  // The clock stands still between words; pins show junk outside the
  // setup and hold span so that a late or early capture is seen.
  task automatic send(input logic [11:0] w, input int gap_ns);
    dac_code_word = ~w;
    #16.3;
    dac_code_word = w;
    #15.7;
    link_clk = 1'b1;
    #16.0;
    dac_code_word = ~w;
    #16.0;
    link_clk = 1'b0;
    #(gap_ns);
  endtask

  // Drives pins with no clock, for transparent mode.
  task automatic present(input logic [11:0] w);
    dac_code_word = w;
  endtask
endmodule
